// *** ret_rot_pkg.sv ***
// constants and types for the return and rotate execution slice
//
// Behaviour
// - return-with-literal loads immediate byte into accumulator
// - return-with-literal pops PC, sets irq enable, two cycles
// - return-from-interrupt pops PC, sets irq enable, two cycles
// - plain return pops PC only, two cycles
// - rotate left: carry into bit0, bit7 to carry
// - rotate right: carry into bit7, bit0 to carry
// - destination select 0 accumulator, 1 memory
`default_nettype none
package ret_rot_pkg;
  localparam int DATA_W  = 8;   // data path width
  localparam int PC_W    = 10;  // program counter width
  localparam int SP_W    = 3;   // stack pointer width
  localparam int ADDR_W  = 6;   // data memory address width
  localparam int MSB_BIT = 7;   // top bit of a data byte
  localparam int LSB_BIT = 0;   // bottom bit of a data byte
  localparam logic [SP_W-1:0]   SP_ONE    = 3'h1;   // one stack step
  localparam logic [SP_W-1:0]   SP_RESET  = 3'h0;   // empty stack
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;  // accumulator after reset
  localparam logic [PC_W-1:0]   PC_RESET  = 10'h000;
  localparam logic              DEST_ACC  = 1'b0;   // destination select: accumulator
  localparam logic              DEST_MEM  = 1'b1;   // destination select: memory byte

  // operations this slice executes
  typedef enum logic [2:0] {
    op_none_type_v,
    op_return_with_literal,
    op_return_from_interrupt,
    op_return_from_subroutine,
    op_rotate_left_through_carry,
    op_rotate_right_through_carry
  } op_type;

  // execution sequencer states
  typedef enum logic [1:0] {
    st_idle,
    st_ret_second
  } exec_state_type;
endpackage
`default_nettype wire

// *** return_and_rotate_exec.sv ***
// execution slice for the return and rotate-through-carry instructions
`timescale 1ns/10ps
`default_nettype none
module return_and_rotate_exec #(
  parameter int STACK_DEPTH = 8  // call stack entries
) (
  // clock and reset
  input  wire logic                            core_clk,
  input  wire logic                            rst_n,
  // instruction issue
  input  wire logic                            issue,
  input  wire ret_rot_pkg::op_type             op,
  input  wire logic [ret_rot_pkg::DATA_W-1:0]  literal,
  input  wire logic                            dest_sel,
  input  wire logic [ret_rot_pkg::ADDR_W-1:0]  mem_addr,
  input  wire logic [ret_rot_pkg::DATA_W-1:0]  mem_rdata,
  // stack push from the call path
  input  wire logic                            push,
  input  wire logic [ret_rot_pkg::PC_W-1:0]    push_addr,
  // irq enable clear by interrupt entry
  input  wire logic                            irq_enable_clear,
  // core state
  output logic                                 busy,
  output logic [ret_rot_pkg::PC_W-1:0]         pc,
  output logic [ret_rot_pkg::DATA_W-1:0]       accumulator,
  output logic                                 carry,
  output logic                                 global_irq_enable,
  output logic [ret_rot_pkg::SP_W-1:0]         stack_ptr,
  // data memory write back
  output logic                                 mem_we,
  output logic [ret_rot_pkg::ADDR_W-1:0]       mem_waddr,
  output logic [ret_rot_pkg::DATA_W-1:0]       mem_wdata
);
  // all checks below run on the core clock and sleep through reset
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////
  // state
  ret_rot_pkg::exec_state_type     state_r, state_nxt;   // sequencer
  logic [ret_rot_pkg::PC_W-1:0]    pc_r, pc_nxt;         // program counter
  logic [ret_rot_pkg::DATA_W-1:0]  acc_r, acc_nxt;       // accumulator
  logic                            carry_r, carry_nxt;   // carry flag
  logic                            gie_r, gie_nxt;       // irq enable
  logic                            set_gie_r, set_gie_nxt; // pending set
  logic [ret_rot_pkg::SP_W-1:0]    sp_r, sp_nxt;         // stack pointer
  logic [ret_rot_pkg::PC_W-1:0]    stack_r [STACK_DEPTH];// stack entries
  logic [ret_rot_pkg::PC_W-1:0]    stack_nxt [STACK_DEPTH];
  logic                            we_r, we_nxt;         // memory write
  logic [ret_rot_pkg::ADDR_W-1:0]  waddr_r, waddr_nxt;
  logic [ret_rot_pkg::DATA_W-1:0]  wdata_r, wdata_nxt;
  logic [ret_rot_pkg::SP_W-1:0]    top_idx;              // top entry index

  rot_if rot ();

  // rotate unit shares the operand byte
  rotate_unit u_rot (
    .rot (rot)
  );

  ////////////////////////////////////////////////////////////////////////
  // drive rotate request
  always_comb begin
    rot.left     = (op == ret_rot_pkg::op_rotate_left_through_carry);
    rot.operand  = mem_rdata;
    rot.carry_in = carry_r;
  end

  // top entry sits one below the pointer; pointer counts filled entries
  always_comb begin
    top_idx = sp_r - ret_rot_pkg::SP_ONE;
  end

  ////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    state_nxt   = state_r;
    pc_nxt      = pc_r;
    acc_nxt     = acc_r;
    carry_nxt   = carry_r;
    gie_nxt     = gie_r;
    set_gie_nxt = set_gie_r;
    sp_nxt      = sp_r;
    stack_nxt   = stack_r;
    we_nxt      = 1'b0;
    waddr_nxt   = waddr_r;
    wdata_nxt   = wdata_r;
    if (irq_enable_clear) begin
      gie_nxt = 1'b0;
    end
    case (state_r)
      ret_rot_pkg::st_idle: begin
        if (push) begin
          // push path for calls; wraps like a hardware stack
          stack_nxt[sp_r] = push_addr;
          sp_nxt          = sp_r + ret_rot_pkg::SP_ONE;
        end else if (issue) begin
          case (op)
            ret_rot_pkg::op_return_with_literal: begin
              acc_nxt     = literal;
              set_gie_nxt = 1'b1;
              state_nxt   = ret_rot_pkg::st_ret_second;
            end
            ret_rot_pkg::op_return_from_interrupt: begin
              set_gie_nxt = 1'b1;
              state_nxt   = ret_rot_pkg::st_ret_second;
            end
            ret_rot_pkg::op_return_from_subroutine: begin
              set_gie_nxt = 1'b0;
              state_nxt   = ret_rot_pkg::st_ret_second;
            end
            ret_rot_pkg::op_rotate_left_through_carry,
            ret_rot_pkg::op_rotate_right_through_carry: begin
              carry_nxt = rot.carry_out;
              if (dest_sel == ret_rot_pkg::DEST_ACC) begin
                acc_nxt = rot.result;
              end else begin
                we_nxt    = 1'b1;
                waddr_nxt = mem_addr;
                wdata_nxt = rot.result;
              end
            end
            default: begin
              // other instructions belong to other slices
            end
          endcase
        end
      end
      ret_rot_pkg::st_ret_second: begin
        // second cycle: load PC from top, then pop
        pc_nxt    = stack_r[top_idx];
        sp_nxt    = top_idx;
        state_nxt = ret_rot_pkg::st_idle;
        if (set_gie_r) begin
          gie_nxt = 1'b1;
        end
        set_gie_nxt = 1'b0;
      end
      default: begin
        state_nxt = ret_rot_pkg::st_idle;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= ret_rot_pkg::st_idle;
      pc_r      <= ret_rot_pkg::PC_RESET;
      acc_r     <= ret_rot_pkg::ACC_RESET;
      carry_r   <= 1'b0;
      gie_r     <= 1'b0;
      set_gie_r <= 1'b0;
      sp_r      <= ret_rot_pkg::SP_RESET;
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stack_r[i] <= ret_rot_pkg::PC_RESET;
      end
      we_r      <= 1'b0;
      waddr_r   <= '0;
      wdata_r   <= ret_rot_pkg::ACC_RESET;
    end else begin
      state_r   <= state_nxt;
      pc_r      <= pc_nxt;
      acc_r     <= acc_nxt;
      carry_r   <= carry_nxt;
      gie_r     <= gie_nxt;
      set_gie_r <= set_gie_nxt;
      sp_r      <= sp_nxt;
      stack_r   <= stack_nxt;
      we_r      <= we_nxt;
      waddr_r   <= waddr_nxt;
      wdata_r   <= wdata_nxt;
    end
  end

  // outputs
  always_comb begin
    busy              = (state_r != ret_rot_pkg::st_idle);
    pc                = pc_r;
    accumulator       = acc_r;
    carry             = carry_r;
    global_irq_enable = gie_r;
    stack_ptr         = sp_r;
    mem_we            = we_r;
    mem_waddr         = waddr_r;
    mem_wdata         = wdata_r;
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_ret_issue;
    issue && !busy && !push &&
    (op == ret_rot_pkg::op_return_with_literal ||
     op == ret_rot_pkg::op_return_from_interrupt ||
     op == ret_rot_pkg::op_return_from_subroutine);
  endsequence

  a_lit_to_acc: assert property (issue && !busy && !push &&
    op == ret_rot_pkg::op_return_with_literal |=> accumulator == $past(literal))
    else $error("literal not loaded");
  a_lit_gie_set: assert property (issue && !busy && !push &&
    op == ret_rot_pkg::op_return_with_literal |=> ##1 global_irq_enable)
    else $error("irq enable not set after literal return");
  a_reti_gie: assert property (issue && !busy && !push &&
    op == ret_rot_pkg::op_return_from_interrupt |=> busy ##1 (!busy && global_irq_enable))
    else $error("interrupt return wrong");
  a_ret_keep_gie: assert property (issue && !busy && !push && !irq_enable_clear &&
    op == ret_rot_pkg::op_return_from_subroutine ##1 !irq_enable_clear
    |=> global_irq_enable == $past(global_irq_enable, 2))
    else $error("plain return touched irq enable");
  a_ret_pc_load: assert property (s_ret_issue |=> ##1
    pc == $past(stack_r[top_idx]) && !busy)
    else $error("pc not loaded from stack");
  a_ret_pop: assert property (s_ret_issue |=> ##1
    stack_ptr == $past(stack_ptr, 2) - ret_rot_pkg::SP_ONE)
    else $error("stack not popped");
  a_rot_left: assert property (issue && !busy && !push &&
    op == ret_rot_pkg::op_rotate_left_through_carry |=>
    carry == $past(mem_rdata[ret_rot_pkg::MSB_BIT]) && !busy)
    else $error("left rotate carry wrong");
  a_rot_right: assert property (issue && !busy && !push &&
    op == ret_rot_pkg::op_rotate_right_through_carry |=>
    carry == $past(mem_rdata[ret_rot_pkg::LSB_BIT]))
    else $error("right rotate carry wrong");
  a_rot_dest: assert property (issue && !busy && !push &&
    (op == ret_rot_pkg::op_rotate_left_through_carry ||
     op == ret_rot_pkg::op_rotate_right_through_carry) |=>
    mem_we == $past(dest_sel))
    else $error("rotate destination wrong");
endmodule
`default_nettype wire

// *** return_and_rotate_exec_tb_top.sv ***
// self-checking bench for the return and rotate execution slice
`timescale 1ns/10ps
`default_nettype none
module return_and_rotate_exec_tb_top;
  ////////////////////////////////////////////////////////////////
  logic                            core_clk;          // bench clock
  logic                            rst_n;             // async reset
  logic                            issue;             // op valid
  ret_rot_pkg::op_type             op;                // operation
  logic [7:0]                      literal;           // return immediate
  logic                            dest_sel;          // rotate target
  logic [ret_rot_pkg::ADDR_W-1:0]  mem_addr;          // operand address
  logic [7:0]                      mem_rdata;         // operand byte
  logic                            push;              // call path push
  logic [ret_rot_pkg::PC_W-1:0]    push_addr;         // pushed address
  logic                            irq_enable_clear;  // irq enable drop
  logic                            busy;
  logic [ret_rot_pkg::PC_W-1:0]    pc;
  logic [7:0]                      accumulator;
  logic                            carry;
  logic                            global_irq_enable;
  logic [ret_rot_pkg::SP_W-1:0]    stack_ptr;
  logic                            mem_we;
  logic [ret_rot_pkg::ADDR_W-1:0]  mem_waddr;
  logic [7:0]                      mem_wdata;
  // bench models of the core state
  logic [ret_rot_pkg::PC_W-1:0]    stk [8];
  logic [ret_rot_pkg::SP_W-1:0]    sp_m;
  logic [7:0]                      acc_m;
  logic                            c_m;
  logic                            gie_m;
  int                              n_fail;
  int                              num_checks;

  return_and_rotate_exec #(.STACK_DEPTH(8)) dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .issue(issue), .op(op), .literal(literal),
    .dest_sel(dest_sel), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .push(push),
    .push_addr(push_addr), .irq_enable_clear(irq_enable_clear), .busy(busy), .pc(pc),
    .accumulator(accumulator), .carry(carry), .global_irq_enable(global_irq_enable),
    .stack_ptr(stack_ptr), .mem_we(mem_we), .mem_waddr(mem_waddr), .mem_wdata(mem_wdata));

  ////////////////////////////////////////////////////////////////
  // 20 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // expected {carry, byte} after one rotate through carry
  function automatic logic [8:0] rot_exp(input logic l, input logic c, input logic [7:0] d);
    if (l) begin
      return {d[7], d[6:0], c};
    end
    return {d[0], c, d[7:1]};
  endfunction

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    if (n_fail == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // one rotate, issue left high so rotates run back to back
  task automatic rot_one(input logic l, input logic d, input logic [7:0] v);
    logic [8:0] e;
    logic [5:0] a;
    e = rot_exp(l, c_m, v);
    a = 6'($urandom);
    issue = 1'b1;
    op = l ? ret_rot_pkg::op_rotate_left_through_carry
           : ret_rot_pkg::op_rotate_right_through_carry;
    dest_sel = d;
    mem_addr = a;
    mem_rdata = v;
    @(negedge core_clk);
    c_m = e[8];
    if (d == ret_rot_pkg::DEST_ACC) begin
      acc_m = e[7:0];
    end
    chk("carry", 16'(carry), 16'(c_m));
    chk("accumulator", 16'(accumulator), 16'(acc_m));
    chk("mem_we", 16'(mem_we), 16'(d));
    if (d == ret_rot_pkg::DEST_MEM) begin
      chk("mem_wdata", 16'(mem_wdata), 16'(e[7:0]));
      chk("mem_waddr", 16'(mem_waddr), 16'(a));
    end
  endtask

  task automatic do_push(input logic [9:0] a);
    push = 1'b1;
    push_addr = a;
    @(negedge core_clk);
    push = 1'b0;
    stk[sp_m] = a;
    sp_m = sp_m + 3'h1;
    chk("push_sp", 16'(stack_ptr), 16'(sp_m));
    @(negedge core_clk);
  endtask

  task automatic clr_gie();
    irq_enable_clear = 1'b1;
    @(negedge core_clk);
    irq_enable_clear = 1'b0;
    gie_m = 1'b0;
    @(negedge core_clk);
  endtask

  // a return: literal at once, pc and pop after the second edge
  task automatic do_ret(input ret_rot_pkg::op_type o, input logic [7:0] lit);
    issue = 1'b1;
    op = o;
    literal = lit;
    @(negedge core_clk);
    issue = 1'b0;
    if (o == ret_rot_pkg::op_return_with_literal) begin
      acc_m = lit;
    end
    if (o != ret_rot_pkg::op_return_from_subroutine) begin
      gie_m = 1'b1;
    end
    chk("busy", 16'(busy), 16'h0001);
    chk("accumulator", 16'(accumulator), 16'(acc_m));
    @(negedge core_clk);
    sp_m = sp_m - 3'h1;
    chk("busy", 16'(busy), 16'h0000);
    chk("pc", 16'(pc), 16'(stk[sp_m]));
    chk("stack_ptr", 16'(stack_ptr), 16'(sp_m));
    chk("irq_enable", 16'(global_irq_enable), 16'(gie_m));
    chk("carry", 16'(carry), 16'(c_m));
  endtask

  ////////////////////////////////////////////////////////////////
  // hang guard
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    finish_test();
  end

  // main sequence
  initial begin
    logic [1:0] k;
    n_fail = 0;
    num_checks = 0;
    rst_n = 1'b0;
    {issue, dest_sel, push, irq_enable_clear} = 4'h0;
    op = ret_rot_pkg::op_none_type_v;
    {literal, mem_rdata, mem_addr, push_addr} = 32'h0;
    {sp_m, acc_m, c_m, gie_m} = 13'h0;
    void'($urandom(32'h16B90D85));
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    rst_n = 1'b1;
    chk("reset_state", 16'({busy, pc, carry, global_irq_enable, mem_we}), 16'h0000);
    chk("reset_acc_sp", {accumulator, 5'h00, stack_ptr}, 16'h0000);
    // corner: A5 left then right to memory, then 01 right and 80 left to accumulator
    rot_one(1'b1, ret_rot_pkg::DEST_MEM, 8'hA5);
    rot_one(1'b0, ret_rot_pkg::DEST_MEM, 8'hA5);
    rot_one(1'b0, ret_rot_pkg::DEST_ACC, 8'h01);
    rot_one(1'b1, ret_rot_pkg::DEST_ACC, 8'h80);
    for (int i = 0; i < 40; i++) begin
      rot_one(1'($urandom), 1'($urandom), 8'($urandom));
    end
    issue = 1'b0;
    @(negedge core_clk);
    // every return kind, with irq enable dropped first
    repeat (3) do_push(10'($urandom));
    clr_gie();
    do_ret(ret_rot_pkg::op_return_with_literal, 8'h55);
    clr_gie();
    do_ret(ret_rot_pkg::op_return_from_subroutine, 8'h00);
    do_ret(ret_rot_pkg::op_return_from_interrupt, 8'h00);
    // corner: rotate, push and irq clear arrive while a return is busy;
    // the first two are refused, the enable set wins over the clear
    do_push(10'h2C3);
    issue = 1'b1;
    op = ret_rot_pkg::op_return_from_interrupt;
    @(negedge core_clk);
    {push, irq_enable_clear, dest_sel} = 3'h7;
    push_addr = 10'h111;
    op = ret_rot_pkg::op_rotate_left_through_carry;
    mem_rdata = {~c_m, 7'h7F};
    @(negedge core_clk);
    {issue, push, irq_enable_clear} = 3'h0;
    sp_m = sp_m - 3'h1;
    gie_m = 1'b1;
    chk("busy_refuse", 16'({busy, mem_we}), 16'h0000);
    chk("pc", 16'(pc), 16'(stk[sp_m]));
    chk("stack_ptr", 16'(stack_ptr), 16'(sp_m));
    chk("irq_enable", 16'(global_irq_enable), 16'(gie_m));
    chk("carry", 16'(carry), 16'(c_m));
    @(negedge core_clk);
    // corner: a push beside a rotate is taken alone; an unknown op does nothing
    issue = 1'b1;
    push = 1'b1;
    push_addr = 10'h0F0;
    @(negedge core_clk);
    stk[sp_m] = 10'h0F0;
    sp_m = sp_m + 3'h1;
    chk("push_first", 16'({carry, mem_we, stack_ptr}), 16'({c_m, 1'b0, sp_m}));
    push = 1'b0;
    op = ret_rot_pkg::op_none_type_v;
    @(negedge core_clk);
    issue = 1'b0;
    chk("unknown_op", 16'({busy, mem_we, carry, accumulator}), 16'({2'h0, c_m, acc_m}));
    @(negedge core_clk);
    do_ret(ret_rot_pkg::op_return_from_subroutine, 8'h00);
    // mid-run reset: asserted between edges, released at the next falling edge
    rst_n = 1'b0;
    @(negedge core_clk);
    rst_n = 1'b1;
    {sp_m, acc_m, c_m, gie_m} = 13'h0;
    chk("reset_state", 16'({busy, pc, carry, global_irq_enable, mem_we}), 16'h0000);
    chk("reset_acc_sp", {accumulator, 5'h00, stack_ptr}, 16'h0000);
    // random mix of calls, returns and rotates
    for (int i = 0; i < 30; i++) begin
      do_push(10'($urandom));
      if (1'($urandom)) begin
        clr_gie();
      end
      k = 2'($urandom % 3);
      do_ret(k == 2'h0 ? ret_rot_pkg::op_return_with_literal :
             k == 2'h1 ? ret_rot_pkg::op_return_from_interrupt :
                         ret_rot_pkg::op_return_from_subroutine, 8'($urandom));
      rot_one(1'($urandom), 1'($urandom), 8'($urandom));
      issue = 1'b0;
      @(negedge core_clk);
    end
    finish_test();
  end
endmodule
`default_nettype wire

// *** rot_if.sv ***
// interface carrying rotate request and result between main and rotate unit
`timescale 1ns/10ps
`default_nettype none
interface rot_if;
  logic                           left;     // 1 rotate left, 0 rotate right
  logic [ret_rot_pkg::DATA_W-1:0] operand;  // byte being rotated
  logic                           carry_in; // carry before the rotate
  logic [ret_rot_pkg::DATA_W-1:0] result;   // rotated byte
  logic                           carry_out;// carry after the rotate
  modport requester (output left, output operand, output carry_in,
                     input result, input carry_out);
  modport rotator (input left, input operand, input carry_in,
                   output result, output carry_out);
endinterface
`default_nettype wire

// *** rotate_unit.sv ***
// combinational rotate-through-carry unit
`timescale 1ns/10ps
`default_nettype none
module rotate_unit (
  // request and result
  rot_if.rotator rot
);
  ////////////////////////////////////////////////////////////////////////
  // pure function so both directions share one place
  function automatic logic [ret_rot_pkg::DATA_W:0] rotate(
    input logic                           left,
    input logic [ret_rot_pkg::DATA_W-1:0] val,
    input logic                           cin);
    logic [ret_rot_pkg::DATA_W:0] r;
    r = '0;
    if (left) begin
      r = {val, cin};
    end else begin
      r = {val[ret_rot_pkg::LSB_BIT], cin,
           val[ret_rot_pkg::MSB_BIT:ret_rot_pkg::LSB_BIT+1]};
    end
    return r;
  endfunction

  // carry-out is the top bit of the packed result
  always_comb begin
    {rot.carry_out, rot.result} = rotate(rot.left, rot.operand, rot.carry_in);
  end
endmodule
`default_nettype wire
